// file: verilog/cod_top.sv
// module: configuration bank for clock drivers two to five
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cod_top
  import cod_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic [DATA_W-1:0]     wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [DATA_W-1:0]     rdata,
  output var cod_pkg::cod_drv_s      clock_driver_two,
  output var cod_pkg::cod_drv_s      clock_driver_three,
  output var cod_pkg::cod_drv_s      clock_driver_four,
  output var cod_pkg::cod_drv_s      clock_driver_five
);
  import cod_pkg::*;

  logic              rst_meta;
  logic              rst_sync_n;
  logic [NUM_DRV-1:0] sel;
  logic [7:0]        val     [NUM_DRV];
  logic              drv_pd  [NUM_DRV];
  logic              pair_pd [NUM_DRV];
  cod_swing_e        swing   [NUM_DRV];
  logic [7:0]        next_rdata;

  // async assert, synchronous release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  assign sel[0] = (addr == ADDR_DRV_TWO);
  assign sel[1] = (addr == ADDR_DRV_THREE);
  assign sel[2] = (addr == ADDR_DRV_FOUR);
  assign sel[3] = (addr == ADDR_DRV_FIVE);

  genvar g;
  generate
    for (g = 0; g < NUM_DRV; g++) begin : g_drv
      // odd registers drop bit four: reserved there, software writes zero
      cod_drv_reg #(
        .MASK ((g % 2 == 0) ? READ_MASK_EVEN : READ_MASK_ODD)
      ) u_reg (
        .clk     (clk),
        .rst_n   (rst_sync_n),
        .wr_en   (wr && sel[g]),
        .wr_data (wdata),
        .value   (val[g]),
        .drv_pd  (drv_pd[g]),
        .pair_pd (pair_pd[g]),
        .swing   (swing[g])
      );
    end
  endgenerate

  // a pair bit in an even register also kills the odd neighbour
  assign clock_driver_two   = '{enable: !(drv_pd[0] || pair_pd[0]), swing: swing[0]};
  assign clock_driver_three = '{enable: !(drv_pd[1] || pair_pd[0]), swing: swing[1]};
  assign clock_driver_four  = '{enable: !(drv_pd[2] || pair_pd[2]), swing: swing[2]};
  assign clock_driver_five  = '{enable: !(drv_pd[3] || pair_pd[2]), swing: swing[3]};

  always_comb begin
    next_rdata = ZERO_BYTE;
    if (rd) begin
      for (int i = 0; i < NUM_DRV; i++) begin
        if (sel[i]) begin
          next_rdata = val[i];
        end
      end
    end
  end

  // read data stand one cycle only; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata <= ZERO_BYTE;
    end else begin
      rdata <= next_rdata;
    end
  end

  property p_reset_default;
    @(posedge clk) $rose(rst_sync_n) |-> clock_driver_four.enable
      && clock_driver_four.swing == COD_SWING_780 && clock_driver_three.enable;
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("bad reset default");

  property p_pair_pd;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[0] && wdata[BIT_PAIR_PD]) |=> !clock_driver_two.enable && !clock_driver_three.enable;
  endproperty
  a_pair_pd: assert property (p_pair_pd) else $error("pair power-down missed");

  property p_drv_pd_only;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[2] && wdata[BIT_DRV_PD] && !pair_pd[2]) |=> !clock_driver_four.enable
      && (clock_driver_five.enable == $past(clock_driver_five.enable));
  endproperty
  a_drv_pd_only: assert property (p_drv_pd_only) else $error("driver power-down wrong");

  property p_swing;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[1]) |=> clock_driver_three.swing == $past(wdata[BIT_SWING_HI:BIT_SWING_LO]);
  endproperty
  a_swing: assert property (p_swing) else $error("swing code not taken");

  property p_dont_care;
    @(posedge clk) disable iff (!rst_sync_n)
      ##1 (val[2] & ~READ_MASK_EVEN) == ZERO_BYTE && (val[3] & ~READ_MASK_ODD) == ZERO_BYTE;
  endproperty
  a_dont_care: assert property (p_dont_care) else $error("don't-care bits stored");

  property p_odd_reserved;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[3]) |=> !pair_pd[3] && clock_driver_five.enable == !drv_pd[3] || pair_pd[2];
  endproperty
  a_odd_reserved: assert property (p_odd_reserved) else $error("odd bit four acted");

  property p_readback;
    @(posedge clk) disable iff (!rst_sync_n)
      (rd && sel[1]) |=> rdata == $past(val[1]);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_read_one_cycle;
    @(posedge clk) disable iff (!rst_sync_n)
      !rd |=> rdata == ZERO_BYTE;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data lingered");

  property p_pair_pd_four;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[2] && wdata[BIT_PAIR_PD]) |=> !clock_driver_four.enable && !clock_driver_five.enable;
  endproperty
  a_pair_pd_four: assert property (p_pair_pd_four) else $error("pair four missed");

  property p_pair_release;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[0] && !wdata[BIT_PAIR_PD] && !wdata[BIT_DRV_PD]) |=> clock_driver_two.enable;
  endproperty
  a_pair_release: assert property (p_pair_release) else $error("driver two stuck off");

  property p_drv_pd_two;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[0] && wdata[BIT_DRV_PD]) |=> !clock_driver_two.enable;
  endproperty
  a_drv_pd_two: assert property (p_drv_pd_two) else $error("driver two still on");

  property p_drv_pd_three;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[1] && wdata[BIT_DRV_PD]) |=> !clock_driver_three.enable
      && (clock_driver_two.enable == $past(clock_driver_two.enable));
  endproperty
  a_drv_pd_three: assert property (p_drv_pd_three) else $error("driver three pd wrong");

  property p_drv_pd_five;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[3] && wdata[BIT_DRV_PD]) |=> !clock_driver_five.enable
      && (clock_driver_four.enable == $past(clock_driver_four.enable));
  endproperty
  a_drv_pd_five: assert property (p_drv_pd_five) else $error("driver five pd wrong");

  property p_swing_two;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[0]) |=> clock_driver_two.swing == $past(wdata[BIT_SWING_HI:BIT_SWING_LO]);
  endproperty
  a_swing_two: assert property (p_swing_two) else $error("swing two not taken");

  property p_swing_four;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[2]) |=> clock_driver_four.swing == $past(wdata[BIT_SWING_HI:BIT_SWING_LO]);
  endproperty
  a_swing_four: assert property (p_swing_four) else $error("swing four not taken");

  property p_swing_five;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[3]) |=> clock_driver_five.swing == $past(wdata[BIT_SWING_HI:BIT_SWING_LO]);
  endproperty
  a_swing_five: assert property (p_swing_five) else $error("swing five not taken");

  property p_reset_all;
    @(posedge clk) $rose(rst_sync_n) |-> clock_driver_two.enable && clock_driver_five.enable
      && clock_driver_two.swing == COD_SWING_780 && clock_driver_five.swing == COD_SWING_780;
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("bad reset default");

  property p_rdata_reset;
    @(posedge clk) !rst_sync_n |-> rdata == ZERO_BYTE;
  endproperty
  a_rdata_reset: assert property (p_rdata_reset) else $error("read data in reset");

  // unmapped writes must leave every register alone
  property p_unmapped_write;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel == '0) |=> val[0] == $past(val[0]) && val[1] == $past(val[1])
      && val[2] == $past(val[2]) && val[3] == $past(val[3]);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored");

  property p_readback_four;
    @(posedge clk) disable iff (!rst_sync_n)
      (rd && sel[2]) |=> rdata == $past(val[2]);
  endproperty
  a_readback_four: assert property (p_readback_four) else $error("readback four wrong");

  property p_read_unmapped;
    @(posedge clk) disable iff (!rst_sync_n)
      (rd && sel == '0) |=> rdata == ZERO_BYTE;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_odd_reserved_three;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr && sel[1]) |=> !pair_pd[1];
  endproperty
  a_odd_reserved_three: assert property (p_odd_reserved_three) else $error("odd bit four kept");
endmodule // cod_top
`default_nettype wire

// file: verilog/cod_pkg.sv
// package: register map, fields and defaults of the clock driver configuration bank
package cod_pkg;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned NUM_DRV      = 4;
  localparam logic [11:0] ADDR_DRV_TWO   = 12'h00f2;
  localparam logic [11:0] ADDR_DRV_THREE = 12'h00f3;
  localparam logic [11:0] ADDR_DRV_FOUR  = 12'h00f4;
  localparam logic [11:0] ADDR_DRV_FIVE  = 12'h00f5;
  localparam int unsigned BIT_DRV_PD   = 0;
  localparam int unsigned BIT_SWING_LO = 1;
  localparam int unsigned BIT_SWING_HI = 2;
  localparam int unsigned BIT_PAIR_PD  = 4;
  localparam logic [7:0]  READ_MASK_EVEN = 8'h17;
  localparam logic [7:0]  READ_MASK_ODD  = 8'h07;
  localparam logic [7:0]  RESET_VAL      = 8'h04;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  typedef enum logic [1:0] {
    COD_SWING_400 = 2'h0,
    COD_SWING_600 = 2'h1,
    COD_SWING_780 = 2'h2,
    COD_SWING_960 = 2'h3
  } cod_swing_e;

  typedef struct packed {
    logic       enable;
    cod_swing_e swing;
  } cod_drv_s;
endpackage : cod_pkg

// file: verilog/cod_drv_reg.sv
// module: one driver configuration register with field decode
`timescale 1ns/1ps
`default_nettype none
module cod_drv_reg
  import cod_pkg::*;
#(
  parameter logic [7:0] MASK = cod_pkg::READ_MASK_EVEN
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            wr_en,
  input  wire logic [7:0]      wr_data,
  output logic      [7:0]      value,
  output logic                 drv_pd,
  output logic                 pair_pd,
  output var cod_pkg::cod_swing_e swing
);
  logic [7:0] next_value;

  always_comb begin
    next_value = value;
    if (wr_en) begin
      // only live bits kept, so don't-care bits cannot reach any output
      next_value = wr_data & MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET_VAL;
    end else begin
      value <= next_value;
    end
  end

  assign drv_pd  = value[BIT_DRV_PD];
  assign pair_pd = value[BIT_PAIR_PD];
  assign swing   = cod_swing_e'(value[BIT_SWING_HI:BIT_SWING_LO]);
endmodule // cod_drv_reg
`default_nettype wire

// file: dv/cod_top_test.sv
// testbench: register access and driver outputs of the clock driver bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module cod_top_test;
  import cod_pkg::*;
  logic       clk, rst_n, wr, rd;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata;
  cod_drv_s    d2, d3, d4, d5;
  logic [2:0]  drv [4];
  int          failures, comparisons;
  assign drv[0] = d2;
  assign drv[1] = d3;
  assign drv[2] = d4;
  assign drv[3] = d5;
  cod_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .clock_driver_two(d2), .clock_driver_three(d3),
    .clock_driver_four(d4), .clock_driver_five(d5));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 `CHK(rdata, e)
  endtask
  task automatic do_reset();
    rst_n = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
  endtask
  // reset values on every register and driver
  task automatic defaults();
    for (int i = 0; i < 4; i++) begin
      rd_chk(12'h00f2 + 12'(i), 8'h04);
      `CHK(drv[i], 3'h6)
    end
    $display("test defaults done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    stop_test();
  end
  initial begin
    {wr, rd, addr, wdata} = '0;
    do_reset();
    defaults();
    // every swing code on every register, each written, checked at the driver and read back
    for (int c = 0; c < 4; c++)
      for (int i = 0; i < 4; i++) begin
        wr_reg(12'h00f2 + 12'(i), 8'(c << 1));
        `CHK(drv[i], {1'b1, 2'(c)})
        rd_chk(12'h00f2 + 12'(i), 8'(c << 1));
      end
    $display("test swing done");
    wr_reg(12'h00f2, 8'h16);
    `CHK({drv[0], drv[1], drv[2]}, 9'h0_df)
    wr_reg(12'h00f4, 8'h16);
    `CHK({drv[2], drv[3]}, 6'h1b)
    wr_reg(12'h00f4, 8'h06);
    wr_reg(12'h00f2, 8'h06);
    wr_reg(12'h00f3, 8'h07);
    `CHK({drv[0], drv[1]}, 6'h3b)
    $display("test power done");
    // odd register three and even register four: don't-care bits written as one are dropped, bit four written as zero
    wr_reg(12'h00f3, 8'hef);
    rd_chk(12'h00f3, 8'h07);
    `CHK({drv[2], drv[3]}, 6'h3f)
    wr_reg(12'h00f3, 8'h06);
    wr_reg(12'h00f4, 8'hee);
    rd_chk(12'h00f4, 8'h06);
    `CHK({drv[2], drv[3]}, 6'h3f)
    $display("test dont care done");
    // unmapped places ignore writes and read zero
    wr_reg(12'h00f6, 8'h11);
    rd_chk(12'h00f6, 8'h00);
    rd_chk(12'h00f1, 8'h00);
    `CHK({drv[0], drv[1], drv[2], drv[3]}, 12'hfff)
    $display("test unmapped done");
    do_reset();
    defaults();
    stop_test();
  end
endmodule // cod_top_test
`default_nettype wire
